// ### design/overlay_window_pkg.sv
// Constants, field layout and decode functions for the overlay window block
package overlay_window_pkg;

  // ----------------------------------------------------------------
  // Register offsets and bus widths
  // ----------------------------------------------------------------
  localparam int          ADDR_WIDTH         = 8;
  localparam int          DATA_WIDTH         = 32;
  localparam int          LANES              = 4;
  localparam logic [7:0]  IMAGE_BASE_OFFSET  = 8'h50;
  localparam logic [7:0]  LINE_STRIDE_OFFSET = 8'h54;
  localparam logic [7:0]  X_BOUNDS_OFFSET    = 8'h58;
  localparam logic [7:0]  Y_BOUNDS_OFFSET    = 8'h5c;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int          BASE_WIDTH   = 17;
  localparam int          STRIDE_WIDTH = 10;
  localparam int          POS_WIDTH    = 10;
  localparam int          START_LSB    = 0;
  localparam int          END_LSB      = 16;
  localparam logic [31:0] BASE_MASK    = 32'h0001ffff;
  localparam logic [31:0] STRIDE_MASK  = 32'h000003ff;
  localparam logic [31:0] POS_MASK     = 32'h03ff03ff;
  localparam logic [31:0] REG_RESET    = 32'h00000000;

  // Byte lane whose write arms the update, per endian strap
  localparam int          LE_TRIGGER_LANE = 3;
  localparam int          BE_TRIGGER_LANE = 0;

  // ----------------------------------------------------------------
  // Colour depth and rotation codes
  // ----------------------------------------------------------------
  localparam logic [2:0]  BPP_1  = 3'h0;
  localparam logic [2:0]  BPP_2  = 3'h1;
  localparam logic [2:0]  BPP_4  = 3'h2;
  localparam logic [2:0]  BPP_8  = 3'h3;
  localparam logic [2:0]  BPP_16 = 3'h4;
  localparam logic [1:0]  ROT_0   = 2'h0;
  localparam logic [1:0]  ROT_90  = 2'h1;
  localparam logic [1:0]  ROT_180 = 2'h2;
  localparam logic [1:0]  ROT_270 = 2'h3;
  localparam logic [5:0]  LINE_UNIT = 6'h01;

  // Pixels covered by one position step when the axis is pixel-stepped
  function automatic logic [5:0] unit_pixels(input logic [2:0] bpp);
    unique case (bpp)
      BPP_1:   unit_pixels = 6'h20;
      BPP_2:   unit_pixels = 6'h10;
      BPP_4:   unit_pixels = 6'h08;
      BPP_8:   unit_pixels = 6'h04;
      default: unit_pixels = 6'h02;
    endcase
  endfunction

  // Usable position bits; the 1024 pixel limit leaves upper bits idle
  function automatic logic [9:0] unit_mask(input logic       pixel_axis,
                                           input logic [2:0] bpp);
    if (!pixel_axis) begin
      unit_mask = 10'h3ff;
    end else begin
      unique case (bpp)
        BPP_1:   unit_mask = 10'h01f;
        BPP_2:   unit_mask = 10'h03f;
        BPP_4:   unit_mask = 10'h07f;
        BPP_8:   unit_mask = 10'h0ff;
        default: unit_mask = 10'h1ff;
      endcase
    end
  endfunction

  // Byte-enable merge of a register write
  function automatic logic [31:0] byte_merge(input logic [31:0] old,
                                             input logic [31:0] wdata,
                                             input logic [3:0]  be);
    byte_merge = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        byte_merge[i*8 +: 8] = wdata[i*8 +: 8];
      end
    end
  endfunction

endpackage

// ### design/overlay_shadow.sv
// Staged-to-active transfer of the overlay bounds during vertical blanking
`timescale 1ns/1ps
`default_nettype none
module overlay_shadow (
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        arm_i,
  input  wire logic        vert_non_display_i,
  input  wire logic [31:0] x_staged_i,
  input  wire logic [31:0] y_staged_i,
  output logic             pending_o,
  output logic [31:0]      x_active_o,
  output logic [31:0]      y_active_o
);
  import overlay_window_pkg::*;

  logic pending;
  logic next_pending;
  logic apply;

  // ----------------------------------------------------------------
  // Pending flag; a new arm beats the clear so it is never lost
  // ----------------------------------------------------------------
  assign apply        = pending & vert_non_display_i;
  assign next_pending = arm_i | (pending & ~apply);

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pending    <= 1'b0;
      x_active_o <= REG_RESET;
      y_active_o <= REG_RESET;
    end else begin
      pending <= next_pending;
      if (apply) begin
        x_active_o <= x_staged_i;
        y_active_o <= y_staged_i;
      end
    end
  end

  assign pending_o = pending;

endmodule
`default_nettype wire

// ### design/overlay_fetch_addr.sv
// Overlay line address generator for the display fetch
`timescale 1ns/1ps
`default_nettype none
module overlay_fetch_addr (
  input  wire logic                                     clk_i,
  input  wire logic                                     reset_n_i,
  input  wire logic                                     frame_start_i,
  input  wire logic                                     line_step_i,
  input  wire logic [overlay_window_pkg::BASE_WIDTH-1:0]   base_i,
  input  wire logic [overlay_window_pkg::STRIDE_WIDTH-1:0] stride_i,
  output logic [overlay_window_pkg::BASE_WIDTH-1:0]        line_addr_o
);
  import overlay_window_pkg::*;

  logic [BASE_WIDTH-1:0] stepped;

  // Wraps inside the double-word space; software keeps the image in range
  assign stepped = line_addr_o + {{(BASE_WIDTH-STRIDE_WIDTH){1'b0}}, stride_i};

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      line_addr_o <= '0;
    end else if (frame_start_i) begin
      line_addr_o <= base_i;
    end else if (line_step_i) begin
      line_addr_o <= stepped;
    end
  end

endmodule
`default_nettype wire

// ### design/overlay_window_registers.sv
// Overlay window register set, update shadowing and fetch placement
`timescale 1ns/1ps
`default_nettype none
module overlay_window_registers (
  input  wire logic                                      clk_i,
  input  wire logic                                      reset_n_i,
  input  wire logic [overlay_window_pkg::ADDR_WIDTH-1:0] reg_addr_i,
  input  wire logic [overlay_window_pkg::DATA_WIDTH-1:0] reg_wdata_i,
  input  wire logic [overlay_window_pkg::LANES-1:0]      reg_be_i,
  input  wire logic                                      reg_wr_i,
  input  wire logic                                      reg_rd_i,
  output logic [overlay_window_pkg::DATA_WIDTH-1:0]      reg_rdata_o,
  input  wire logic                                      endian_strap_i,
  input  wire logic                                      overlay_enable_i,
  input  wire logic [2:0]                                bpp_code_i,
  input  wire logic [1:0]                                rotation_i,
  input  wire logic                                      vert_non_display_i,
  input  wire logic                                      line_done_i,
  input  wire logic [overlay_window_pkg::POS_WIDTH-1:0]  scan_line_i,
  input  wire logic [overlay_window_pkg::POS_WIDTH-1:0]  scan_col_i,
  output logic [overlay_window_pkg::BASE_WIDTH-1:0]      fetch_addr_o,
  output logic                                           overlay_hit_o,
  output logic [5:0]                                     x_unit_pixels_o,
  output logic [5:0]                                     y_unit_pixels_o,
  output logic [overlay_window_pkg::POS_WIDTH-1:0]       x_start_o,
  output logic [overlay_window_pkg::POS_WIDTH-1:0]       x_end_o,
  output logic [overlay_window_pkg::POS_WIDTH-1:0]       y_start_o,
  output logic [overlay_window_pkg::POS_WIDTH-1:0]       y_end_o,
  output logic                                           update_pending_o,
  output logic                                           endian_big_o
);
  import overlay_window_pkg::*;

  // ----------------------------------------------------------------
  // Endian strap capture
  // ----------------------------------------------------------------
  logic strap_s1;
  logic strap_s2;
  logic strap_s3;
  logic strap_taken;
  logic endian_big;
  logic [1:0] strap_fill;
  wire        strap_full = &strap_fill;

  // Caught once after reset; a later strap change is deliberately ignored
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      strap_s1    <= 1'b0;
      strap_s2    <= 1'b0;
      strap_s3    <= 1'b0;
      strap_taken <= 1'b0;
      endian_big  <= 1'b0;
      strap_fill  <= 2'h0;
    end else begin
      strap_s1 <= endian_strap_i;
      strap_s2 <= strap_s1;
      strap_s3 <= strap_s2;
      // Stages hold reset zeros until the pin has reached the last one
      if (!strap_full) begin
        strap_fill <= strap_fill + 2'h1;
      end
      if (!strap_taken && strap_full && (strap_s2 == strap_s3)) begin
        strap_taken <= 1'b1;
        endian_big  <= strap_s3;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register decode and staged storage
  // ----------------------------------------------------------------
  logic [31:0] image_base_word;
  logic [31:0] line_stride_word;
  logic [31:0] x_stage;
  logic [31:0] y_stage;
  wire         base_hit   = (reg_addr_i == IMAGE_BASE_OFFSET);
  wire         stride_hit = (reg_addr_i == LINE_STRIDE_OFFSET);
  wire         x_hit      = (reg_addr_i == X_BOUNDS_OFFSET);
  wire         y_hit      = (reg_addr_i == Y_BOUNDS_OFFSET);
  wire         x_write    = reg_wr_i & x_hit;
  wire         y_write    = reg_wr_i & y_hit;
  wire         trigger_lane;
  wire         arm_write;

  assign trigger_lane = endian_big ? reg_be_i[BE_TRIGGER_LANE]
                                   : reg_be_i[LE_TRIGGER_LANE];
  assign arm_write    = y_write & trigger_lane;

  // Reserved bits are masked so they always read back as zero
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      image_base_word  <= REG_RESET;
      line_stride_word <= REG_RESET;
      x_stage          <= REG_RESET;
      y_stage          <= REG_RESET;
    end else begin
      if (reg_wr_i && base_hit) begin
        image_base_word <= byte_merge(image_base_word, reg_wdata_i,
                                      reg_be_i) & BASE_MASK;
      end
      if (reg_wr_i && stride_hit) begin
        line_stride_word <= byte_merge(line_stride_word, reg_wdata_i,
                                       reg_be_i) & STRIDE_MASK;
      end
      if (x_write) begin
        x_stage <= byte_merge(x_stage, reg_wdata_i, reg_be_i) & POS_MASK;
      end
      if (y_write) begin
        y_stage <= byte_merge(y_stage, reg_wdata_i, reg_be_i) & POS_MASK;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  wire [31:0] read_mux = base_hit   ? image_base_word  :
                         stride_hit ? line_stride_word :
                         x_hit      ? x_stage          :
                         y_hit      ? y_stage          : 32'h00000000;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= REG_RESET;
    end else begin
      reg_rdata_o <= reg_rd_i ? read_mux : REG_RESET;
    end
  end

  // ----------------------------------------------------------------
  // Shadowed bounds
  // ----------------------------------------------------------------
  logic [31:0] x_active;
  logic [31:0] y_active;
  logic        update_pending;

  overlay_shadow u_shadow (
    .clk_i              (clk_i),
    .reset_n_i          (reset_n_i),
    .arm_i              (arm_write),
    .vert_non_display_i (vert_non_display_i),
    .x_staged_i         (x_stage),
    .y_staged_i         (y_stage),
    .pending_o          (update_pending),
    .x_active_o         (x_active),
    .y_active_o         (y_active)
  );

  // ----------------------------------------------------------------
  // Axis mapping, step sizes and usable bits
  // ----------------------------------------------------------------
  wire       rotated = (rotation_i == ROT_90) | (rotation_i == ROT_270);
  wire [5:0] group   = unit_pixels(bpp_code_i);
  wire [9:0] x_mask  = unit_mask(~rotated, bpp_code_i);
  wire [9:0] y_mask  = unit_mask(rotated, bpp_code_i);
  wire [5:0] next_x_unit = rotated ? LINE_UNIT : group;
  wire [5:0] next_y_unit = rotated ? group : LINE_UNIT;
  wire [9:0] x_start_f = x_active[START_LSB +: POS_WIDTH] & x_mask;
  wire [9:0] x_end_f   = x_active[END_LSB +: POS_WIDTH] & x_mask;
  wire [9:0] y_start_f = y_active[START_LSB +: POS_WIDTH] & y_mask;
  wire [9:0] y_end_f   = y_active[END_LSB +: POS_WIDTH] & y_mask;

  // Rotation swaps which field pair walks lines and which walks columns
  wire [9:0] line_lo = rotated ? x_start_f : y_start_f;
  wire [9:0] line_hi = rotated ? x_end_f   : y_end_f;
  wire [9:0] col_lo  = rotated ? y_start_f : x_start_f;
  wire [9:0] col_hi  = rotated ? y_end_f   : x_end_f;
  wire       in_lines = (scan_line_i >= line_lo) & (scan_line_i <= line_hi);
  wire       in_cols  = (scan_col_i >= col_lo) & (scan_col_i <= col_hi);

  // ----------------------------------------------------------------
  // Fetch placement
  // ----------------------------------------------------------------
  logic vnd_q;
  wire  frame_start = vnd_q & ~vert_non_display_i;
  wire  line_step   = overlay_enable_i & line_done_i & in_lines;
  wire  next_hit    = overlay_enable_i & in_lines & in_cols;

  overlay_fetch_addr u_fetch (
    .clk_i         (clk_i),
    .reset_n_i     (reset_n_i),
    .frame_start_i (frame_start),
    .line_step_i   (line_step),
    .base_i        (image_base_word[BASE_WIDTH-1:0]),
    .stride_i      (line_stride_word[STRIDE_WIDTH-1:0]),
    .line_addr_o   (fetch_addr_o)
  );

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      vnd_q            <= 1'b0;
      overlay_hit_o    <= 1'b0;
      x_unit_pixels_o  <= LINE_UNIT;
      y_unit_pixels_o  <= LINE_UNIT;
      x_start_o        <= '0;
      x_end_o          <= '0;
      y_start_o        <= '0;
      y_end_o          <= '0;
      update_pending_o <= 1'b0;
      endian_big_o     <= 1'b0;
    end else begin
      vnd_q            <= vert_non_display_i;
      overlay_hit_o    <= next_hit;
      x_unit_pixels_o  <= next_x_unit;
      y_unit_pixels_o  <= next_y_unit;
      x_start_o        <= x_start_f;
      x_end_o          <= x_end_f;
      y_start_o        <= y_start_f;
      y_end_o          <= y_end_f;
      update_pending_o <= update_pending;
      endian_big_o     <= endian_big;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_arm_sets_pending:
    assert property (@(posedge clk_i) disable iff (!reset_n_i)
      arm_write |=> update_pending ##1 update_pending_o)
    else $error("Armed Y write did not raise pending");

  a_x_write_inert:
    assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (x_write && !update_pending && !arm_write) |=> !update_pending)
    else $error("X write alone armed the update");

  a_hold_in_display:
    assert property (@(posedge clk_i) disable iff (!reset_n_i)
      !vert_non_display_i |=> ($stable(x_active) && $stable(y_active)))
    else $error("Bounds changed outside vertical blanking");

  a_little_lane_arm:
    assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (y_write && !endian_big && reg_be_i[3]) |=> update_pending)
    else $error("Little endian top byte write did not arm");

  a_big_lane_arm:
    assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (y_write && endian_big && reg_be_i[0] && !reg_be_i[3]) |=>
      update_pending)
    else $error("Big endian low byte write did not arm");

  a_x_end_field:
    assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (update_pending && vert_non_display_i) |=>
      x_active[25:16] == $past(x_stage[25:16]))
    else $error("X end field not applied from bits 25-16");

  a_x_start_field:
    assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (update_pending && vert_non_display_i) |=>
      x_active[9:0] == $past(x_stage[9:0]))
    else $error("X start field not applied from bits 9-0");

  a_group_unit:
    assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (!rotated && bpp_code_i == BPP_1) |=> x_unit_pixels_o == 6'h20)
    else $error("Unrotated 1 bpp X step is not 32 pixels");

  a_line_unit:
    assert property (@(posedge clk_i) disable iff (!reset_n_i)
      rotated |=> (x_unit_pixels_o == 6'h01))
    else $error("Rotated X step is not one line");

  a_y_group_unit:
    assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (rotated && bpp_code_i == BPP_16) |=> y_unit_pixels_o == 6'h02)
    else $error("Rotated 16 bpp Y step is not 2 pixels");

  a_hit_needs_enable:
    assert property (@(posedge clk_i) disable iff (!reset_n_i)
      !overlay_enable_i |=> !overlay_hit_o)
    else $error("Overlay hit without enable");

  a_base_at_frame:
    assert property (@(posedge clk_i) disable iff (!reset_n_i)
      frame_start |=> fetch_addr_o == $past(image_base_word[16:0]))
    else $error("Fetch did not restart at the start address");

  a_stride_step:
    assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (line_step && !frame_start) |=>
      fetch_addr_o == 17'($past(fetch_addr_o) +
                          {7'h00, $past(line_stride_word[9:0])}))
    else $error("Line advance is not one stride");

  a_idle_address:
    assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (!line_step && !frame_start) |=> $stable(fetch_addr_o))
    else $error("Fetch address moved without a line step");

endmodule
`default_nettype wire

// ### verification/tb.sv
// Self-checking testbench for the overlay window register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, want) begin \
  checks_done++; \
  if ((got) !== (want)) begin \
    err_total++; \
    $display("unexpected at %0t: got %0h want %0h", $time, got, want); \
  end \
end
module tb;
  import overlay_window_pkg::*;
  logic        clk = 0, reset_n = 0, wr = 0, rd = 0, strap = 0;
  logic        en = 0, vnd = 0, ldone = 0, hit, pend, big;
  logic [7:0]  addr = 0;
  logic [31:0] wdata = 0, rdata;
  logic [3:0]  be = 0;
  logic [2:0]  bpp = BPP_16;
  logic [1:0]  rot = ROT_0;
  logic [9:0]  sline = 0, scol = 0, xs, xe, ys, ye;
  logic [16:0] faddr;
  logic [5:0]  xu, yu;
  int          err_total = 0, checks_done = 0;

  always #10 clk = ~clk;

  overlay_window_registers DUT (
    .clk_i(clk), .reset_n_i(reset_n), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_be_i(be), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .endian_strap_i(strap), .overlay_enable_i(en),
    .bpp_code_i(bpp), .rotation_i(rot), .vert_non_display_i(vnd),
    .line_done_i(ldone), .scan_line_i(sline), .scan_col_i(scol),
    .fetch_addr_o(faddr), .overlay_hit_o(hit), .x_unit_pixels_o(xu),
    .y_unit_pixels_o(yu), .x_start_o(xs), .x_end_o(xe), .y_start_o(ys),
    .y_end_o(ye), .update_pending_o(pend), .endian_big_o(big)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic give_verdict;
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Strap is only sampled after release, so it is set before reset
  task automatic do_reset(input logic s);
    strap = s;
    reset_n = 0;
    cyc(4);
    reset_n = 1;
    cyc(6);
    `CHK(big, s)
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] b);
    addr = a;
    wdata = d;
    be = b;
    wr = 1;
    cyc(1);
    wr = 0;
    cyc(1);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] w);
    addr = a;
    rd = 1;
    cyc(1);
    rd = 0;
    `CHK(rdata, w)
    cyc(1);
  endtask

  task automatic step_line;
    ldone = 1;
    cyc(1);
    ldone = 0;
    cyc(1);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    rd_chk(IMAGE_BASE_OFFSET, 32'h0);
    rd_chk(LINE_STRIDE_OFFSET, 32'h0);
    rd_chk(X_BOUNDS_OFFSET, 32'h0);
    rd_chk(Y_BOUNDS_OFFSET, 32'h0);
    `CHK(faddr, 17'h0)
    `CHK(pend, 1'b0)
  endtask

  task automatic t_regs;
    wr_reg(IMAGE_BASE_OFFSET, 32'hffffffff, 4'hf);
    rd_chk(IMAGE_BASE_OFFSET, 32'h0001ffff);
    wr_reg(IMAGE_BASE_OFFSET, 32'h00000001, 4'hf);
    rd_chk(IMAGE_BASE_OFFSET, 32'h00000001);
    wr_reg(LINE_STRIDE_OFFSET, 32'hffffffff, 4'hf);
    rd_chk(LINE_STRIDE_OFFSET, 32'h000003ff);
    wr_reg(X_BOUNDS_OFFSET, 32'hffffffff, 4'hf);
    wr_reg(X_BOUNDS_OFFSET, 32'h00aa0000, 4'h4);
    rd_chk(X_BOUNDS_OFFSET, 32'h03aa03ff);
    // Low lanes only: staged but not armed under little endian
    wr_reg(Y_BOUNDS_OFFSET, 32'hffffffff, 4'h3);
    rd_chk(Y_BOUNDS_OFFSET, 32'h000003ff);
    `CHK(pend, 1'b0)
    wr_reg(8'h60, 32'hffffffff, 4'hf);
    rd_chk(8'h60, 32'h0);
  endtask

  task automatic t_units;
    logic [5:0] px;
    for (int r = 0; r < 4; r++) begin
      for (int c = 0; c < 5; c++) begin
        rot = r[1:0];
        bpp = c[2:0];
        px = 6'h20 >> c;
        cyc(2);
        `CHK(xu, r[0] ? 6'h01 : px)
        `CHK(yu, r[0] ? px : 6'h01)
      end
    end
    rot = ROT_0;
    bpp = BPP_16;
    cyc(2);
  endtask

  task automatic t_shadow_le;
    wr_reg(X_BOUNDS_OFFSET, 32'h00400010, 4'hf);
    wr_reg(Y_BOUNDS_OFFSET, 32'h00200004, 4'hf);
    cyc(2);
    `CHK(pend, 1'b1)
    cyc(5);
    // Active bounds still hold their reset value until blanking
    `CHK(xe, 10'h000)
    vnd = 1;
    cyc(4);
    `CHK(xs, 10'h010)
    `CHK(xe, 10'h040)
    `CHK(ys, 10'h004)
    `CHK(ye, 10'h020)
    `CHK(pend, 1'b0)
    vnd = 0;
    cyc(2);
  endtask

  task automatic t_fetch;
    en = 1;
    wr_reg(IMAGE_BASE_OFFSET, 32'h00000100, 4'hf);
    wr_reg(LINE_STRIDE_OFFSET, 32'h00000020, 4'hf);
    vnd = 1;
    cyc(1);
    vnd = 0;
    cyc(2);
    `CHK(faddr, 17'h00100)
    en = 0;
    sline = 10'h005;
    step_line();
    `CHK(faddr, 17'h00100)
    en = 1;
    step_line();
    `CHK(faddr, 17'h00120)
    sline = 10'h030;
    step_line();
    `CHK(faddr, 17'h00120)
    sline = 10'h005;
    scol = 10'h020;
    cyc(2);
    `CHK(hit, 1'b1)
    en = 0;
    cyc(2);
    `CHK(hit, 1'b0)
    en = 1;
    sline = 10'h030;
    scol = 10'h008;
    cyc(2);
    `CHK(hit, 1'b0)
    // Rotated: X bounds the line axis, Y the column axis
    rot = ROT_90;
    cyc(2);
    `CHK(hit, 1'b1)
    rot = ROT_0;
    en = 0;
  endtask

  task automatic t_shadow_be;
    bpp = BPP_8;
    wr_reg(X_BOUNDS_OFFSET, 32'h03ff0155, 4'hf);
    wr_reg(Y_BOUNDS_OFFSET, 32'h03000012, 4'h8);
    cyc(2);
    `CHK(pend, 1'b0)
    wr_reg(Y_BOUNDS_OFFSET, 32'h03000012, 4'h1);
    cyc(2);
    `CHK(pend, 1'b1)
    vnd = 1;
    cyc(4);
    vnd = 0;
    `CHK(xe, 10'h0ff)
    `CHK(xs, 10'h055)
    `CHK(ye, 10'h300)
    `CHK(ys, 10'h012)
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    do_reset(1'b0);
    t_reset();
    t_regs();
    t_units();
    t_shadow_le();
    t_fetch();
    do_reset(1'b1);
    t_shadow_be();
    give_verdict();
  end

  // Whole run is about 150 cycles; this leaves wide margin
  initial begin
    #200000;
    err_total++;
    give_verdict();
  end
endmodule
`default_nettype wire
